// File: verilog/laq_pkg.sv
package laq_pkg;
    localparam int LAQ_CHANNELS = 4;
    localparam int LAQ_ADDR_W = 8;
    localparam int LAQ_DATA_W = 24;
    localparam logic [7:0] LAQ_UV_QUALIFY_OFFSET = 8'h48;
    localparam logic [7:0] LAQ_ALERT_ENABLE_OFFSET = 8'h49;
    localparam logic [7:0] LAQ_UV_QUALIFY_RESET = 8'h00;
    localparam logic [23:0] LAQ_ALERT_ENABLE_RESET = 24'h000000;
    localparam logic [23:0] LAQ_ALERT_ENABLE_MASK = 24'hfffffe;
    localparam int LAQ_OC_LSB = 20;
    localparam int LAQ_UC_LSB = 16;
    localparam int LAQ_OV_LSB = 12;
    localparam int LAQ_UV_LSB = 8;
    localparam int LAQ_OP_LSB = 4;
    localparam int LAQ_ACC_FULL_BIT = 3;
    localparam int LAQ_ACC_TALLY_BIT = 2;
    localparam int LAQ_CYCLE_DONE_BIT = 1;
    localparam int LAQ_ALERT_COUNT = 23;
    localparam logic [4:0] LAQ_COUNT_ONE = 5'h01;
    localparam logic [4:0] LAQ_COUNT_FOUR = 5'h04;
    localparam logic [4:0] LAQ_COUNT_EIGHT = 5'h08;
    localparam logic [4:0] LAQ_COUNT_SIXTEEN = 5'h10;
    typedef enum logic [1:0] {
        LAQ_HOST_IDLE,
        LAQ_HOST_DISABLE,
        LAQ_HOST_WRITE,
        LAQ_HOST_REFRESH
    } laq_host_state_e;
endpackage

// File: verilog/laq_if.sv
`timescale 1ns/1ps
interface laq_if;
    logic wr_en;
    logic [7:0] addr;
    logic [23:0] wdata;
    logic [23:0] rdata;
    logic refresh;
    modport device (input wr_en, input addr, input wdata, input refresh,
        output rdata);
    modport host (output wr_en, output addr, output wdata, output refresh,
        input rdata);
endinterface

// File: verilog/laq_device.sv
`timescale 1ns/1ps
// What this block does
// - uv field codes select 1,4,8,16 samples
// - uv fields at bits 7:6 down 1:0
// - uv fields reset to one sample
// - host disables alerts before changing counts; the cleared enables only apply at the refresh after the count write
// - one enables an alert, zero disables
// - alert reaches pin only when enabled
// - host disables alerts before changing limits
// - new enables apply after refresh only
// - bits 23:20 enable overcurrent channels 1-4
// - bits 19:16 enable undercurrent channels 1-4
// - bits 15:12 enable overvoltage channels 1-4
// - bits 11:8 enable undervoltage channels 1-4
// - bits 7:4 enable overpower channels 1-4
// - bits 3:1 accumulator, tally, cycle; bit0 zero
module laq_device
    import laq_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    laq_if.device bus,
    input wire logic sample_valid,
    input wire logic [3:0] uv_below_limit,
    input wire logic [3:0] overcurrent_cond,
    input wire logic [3:0] undercurrent_cond,
    input wire logic [3:0] overvoltage_cond,
    input wire logic [3:0] overpower_cond,
    input wire logic accum_full_cond,
    input wire logic accum_tally_full_cond,
    input wire logic cycle_done_cond,
    output logic [3:0] uv_qualified,
    output logic [22:0] alert_gated,
    output logic alert_any
);
    logic [7:0] uv_qualify_reg;
    logic [7:0] uv_qualify_next;
    logic [23:0] enable_reg;
    logic [23:0] enable_next;
    logic [23:0] active_en_reg;
    logic [23:0] active_en_next;
    logic [4:0] uv_cnt_reg [LAQ_CHANNELS];
    logic [4:0] uv_cnt_next [LAQ_CHANNELS];
    logic [3:0] uv_qual_reg;
    logic [3:0] uv_qual_next;
    logic [22:0] gated_reg;
    logic [22:0] gated_next;
    logic any_reg;
    logic any_next;
    logic [23:0] cond;

    function automatic logic [4:0] laq_needed(input logic [1:0] code);
        case (code)
            2'h0: laq_needed = LAQ_COUNT_ONE;
            2'h1: laq_needed = LAQ_COUNT_FOUR;
            2'h2: laq_needed = LAQ_COUNT_EIGHT;
            default: laq_needed = LAQ_COUNT_SIXTEEN;
        endcase
    endfunction

    // pins carry channel 1 in the top bit, the counters in index 0
    function automatic logic [3:0] laq_ch_order(input logic [3:0] v);
        laq_ch_order = {v[0], v[1], v[2], v[3]};
    endfunction

    function automatic logic laq_hit(input logic [7:0] a,
        input logic [7:0] offset);
        laq_hit = (a == offset);
    endfunction

    // register writes; enables latch into the active set only on refresh
    always_comb
    begin
        uv_qualify_next = uv_qualify_reg;
        enable_next = enable_reg;
        active_en_next = active_en_reg;
        if (bus.wr_en && laq_hit(bus.addr, LAQ_UV_QUALIFY_OFFSET))
        begin
            uv_qualify_next = bus.wdata[7:0];
        end
        if (bus.wr_en && laq_hit(bus.addr, LAQ_ALERT_ENABLE_OFFSET))
        begin
            enable_next = bus.wdata & LAQ_ALERT_ENABLE_MASK;
        end
        // refresh takes the enables as they stood before this edge
        if (bus.refresh)
        begin
            active_en_next = enable_reg;
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            uv_qualify_reg <= LAQ_UV_QUALIFY_RESET;
            enable_reg <= LAQ_ALERT_ENABLE_RESET;
            active_en_reg <= LAQ_ALERT_ENABLE_RESET;
        end
        else
        begin
            uv_qualify_reg <= uv_qualify_next;
            enable_reg <= enable_next;
            active_en_reg <= active_en_next;
        end
    end

    // read mux, bit 0 of enables reads zero
    always_comb
    begin
        bus.rdata = 24'h000000;
        if (laq_hit(bus.addr, LAQ_UV_QUALIFY_OFFSET))
        begin
            bus.rdata = {16'h0000, uv_qualify_reg};
        end
        else if (laq_hit(bus.addr, LAQ_ALERT_ENABLE_OFFSET))
        begin
            bus.rdata = enable_reg;
        end
    end

    // uv consecutive-sample qualifiers, channel 1 in bits 7:6
    always_comb
    begin
        logic [1:0] code;
        logic [4:0] need;
        code = 2'h0;
        need = LAQ_COUNT_ONE;
        for (int i = 0; i < LAQ_CHANNELS; i++)
        begin
            code = uv_qualify_reg[7 - 2 * i -: 2];
            need = laq_needed(code);
            uv_cnt_next[i] = uv_cnt_reg[i];
            uv_qual_next[i] = uv_qual_reg[i];
            if (sample_valid)
            begin
                if (uv_below_limit[3 - i])
                begin
                    // saturate at the target so the count cannot wrap
                    if (uv_cnt_reg[i] < need)
                    begin
                        uv_cnt_next[i] = uv_cnt_reg[i] + 5'h01;
                    end
                    uv_qual_next[i] = (uv_cnt_reg[i] + 5'h01)
                        >= need;
                end
                else
                begin
                    uv_cnt_next[i] = 5'h00;
                    uv_qual_next[i] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < LAQ_CHANNELS; i++)
            begin
                uv_cnt_reg[i] <= 5'h00;
            end
            uv_qual_reg <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < LAQ_CHANNELS; i++)
            begin
                uv_cnt_reg[i] <= uv_cnt_next[i];
            end
            uv_qual_reg <= uv_qual_next;
        end
    end

    // channel 1 in the top bit of each group
    always_comb
    begin
        cond = 24'h000000;
        cond[LAQ_OC_LSB +: 4] = overcurrent_cond;
        cond[LAQ_UC_LSB +: 4] = undercurrent_cond;
        cond[LAQ_OV_LSB +: 4] = overvoltage_cond;
        cond[LAQ_UV_LSB +: 4] = laq_ch_order(uv_qual_reg);
        cond[LAQ_OP_LSB +: 4] = overpower_cond;
        cond[LAQ_ACC_FULL_BIT] = accum_full_cond;
        cond[LAQ_ACC_TALLY_BIT] = accum_tally_full_cond;
        cond[LAQ_CYCLE_DONE_BIT] = cycle_done_cond;
        gated_next = cond[23:1] & active_en_reg[23:1];
        any_next = |gated_next;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            gated_reg <= 23'h000000;
            any_reg <= 1'b0;
        end
        else
        begin
            gated_reg <= gated_next;
            any_reg <= any_next;
        end
    end

    assign uv_qualified = laq_ch_order(uv_qual_reg);
    assign alert_gated = gated_reg;
    assign alert_any = any_reg;
endmodule

// File: verilog/laq_host.sv
`timescale 1ns/1ps
module laq_host
    import laq_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    laq_if.host bus,
    input wire logic cfg_start,
    input wire logic cfg_is_enable,
    input wire logic [23:0] cfg_data,
    input wire logic [7:0] rd_addr,
    output logic cfg_busy,
    output logic [23:0] rd_data
);
    laq_host_state_e state_reg;
    laq_host_state_e state_next;
    logic is_en_reg;
    logic is_en_next;
    logic [23:0] data_reg;
    logic [23:0] data_next;
    logic [23:0] rd_data_next;

    // counts and limits change with the enable register cleared; the active enables clear only at the refresh after
    always_comb
    begin
        state_next = state_reg;
        is_en_next = is_en_reg;
        data_next = data_reg;
        bus.wr_en = 1'b0;
        bus.addr = rd_addr;
        bus.wdata = 24'h000000;
        bus.refresh = 1'b0;
        case (state_reg)
            LAQ_HOST_IDLE:
            begin
                if (cfg_start)
                begin
                    is_en_next = cfg_is_enable;
                    data_next = cfg_data;
                    state_next = cfg_is_enable ? LAQ_HOST_WRITE
                        : LAQ_HOST_DISABLE;
                end
            end
            LAQ_HOST_DISABLE:
            begin
                bus.wr_en = 1'b1;
                bus.addr = LAQ_ALERT_ENABLE_OFFSET;
                bus.wdata = LAQ_ALERT_ENABLE_RESET;
                state_next = LAQ_HOST_WRITE;
            end
            LAQ_HOST_WRITE:
            begin
                bus.wr_en = 1'b1;
                bus.addr = is_en_reg ? LAQ_ALERT_ENABLE_OFFSET
                    : LAQ_UV_QUALIFY_OFFSET;
                bus.wdata = is_en_reg ? data_reg
                    : {16'h0000, data_reg[7:0]};
                state_next = LAQ_HOST_REFRESH;
            end
            LAQ_HOST_REFRESH:
            begin
                bus.refresh = 1'b1;
                state_next = LAQ_HOST_IDLE;
            end
            default: state_next = LAQ_HOST_IDLE;
        endcase
        rd_data_next = bus.rdata;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= LAQ_HOST_IDLE;
            is_en_reg <= 1'b0;
            data_reg <= 24'h000000;
            rd_data <= 24'h000000;
        end
        else
        begin
            state_reg <= state_next;
            is_en_reg <= is_en_next;
            data_reg <= data_next;
            rd_data <= rd_data_next;
        end
    end

    assign cfg_busy = (state_reg != LAQ_HOST_IDLE);
endmodule

// File: tb/laq_check_sva.sv
`timescale 1ns/1ps
module laq_check_sva (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [7:0] addr,
    input wire logic [23:0] wdata,
    input wire logic [23:0] rdata,
    input wire logic refresh
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);
    AST_EN_REFRESH: assert property (wr_en && addr == 8'h49 |=>
        refresh || (wr_en && addr == 8'h48)) else $error("no refresh");
    AST_UV_REFRESH: assert property (wr_en && addr == 8'h48 |=>
        refresh) else $error("no refresh after count write");
    AST_UV_ORDER: assert property (wr_en && addr == 8'h48 |->
        $past(wr_en) && $past(addr) == 8'h49 && $past(wdata) == 24'h0)
        else $error("counts changed with alerts on");
    AST_REFRESH_PULSE: assert property (refresh |=>
        !refresh && !wr_en) else $error("refresh not a pulse");
    AST_BIT0_ZERO: assert property (addr == 8'h49 |->
        !rdata[0]) else $error("enable bit 0 set");
    AST_UV_WIDTH: assert property (addr == 8'h48 |->
        rdata[23:8] == 16'h0) else $error("count reg too wide");
    AST_UNMAPPED: assert property (addr != 8'h48 && addr != 8'h49 |->
        rdata == 24'h0) else $error("unmapped read nonzero");
    AST_WR_SEEN: assert property (wr_en && addr == 8'h49 ##1
        addr == 8'h49 |-> rdata == ($past(wdata) & 24'hfffffe))
        else $error("enable write lost");
    AST_RESET_VAL: assert property ($past(sys_rst) &&
        (addr == 8'h48 || addr == 8'h49) |-> rdata == 24'h0)
        else $error("reset value wrong");
    cover property (wr_en && addr == 8'h48);
    cover property (refresh);
    cover property (addr == 8'h49 && rdata != 24'h0);
endmodule

// File: tb/test_limit_alert_qualify_enable.sv
`timescale 1ns/1ps
module test_limit_alert_qualify_enable;
    import laq_pkg::*;
    logic clock = 0, sys_rst = 1, sample_valid = 0, cfg_start = 0;
    logic cfg_is_enable = 0, acc = 0, tally = 0, cyc = 0, alert_any;
    logic [3:0] uv_below = 0, oc = 0, uc = 0, ov = 0, op = 0, q;
    logic [3:0] uv_qualified;
    logic [7:0] rd_addr = 8'h49, c, p;
    logic [23:0] cfg_data = 0, rd_data, g;
    logic [22:0] alert_gated;
    logic cfg_busy;
    logic [31:0] seed = 32'h23b7, r, r2;
    logic [28:0] e, exp_q[$];
    event look;
    int n_fail = 0, total_checks = 0, n, k;
    laq_if bus_if();
    laq_device i_laq_device(.clock(clock), .sys_rst(sys_rst),
        .bus(bus_if), .sample_valid(sample_valid),
        .uv_below_limit(uv_below), .overcurrent_cond(oc),
        .undercurrent_cond(uc), .overvoltage_cond(ov),
        .overpower_cond(op), .accum_full_cond(acc),
        .accum_tally_full_cond(tally), .cycle_done_cond(cyc),
        .uv_qualified(uv_qualified), .alert_gated(alert_gated),
        .alert_any(alert_any));
    laq_host i_laq_host(.clock(clock), .sys_rst(sys_rst), .bus(bus_if),
        .cfg_start(cfg_start), .cfg_is_enable(cfg_is_enable),
        .cfg_data(cfg_data), .rd_addr(rd_addr), .cfg_busy(cfg_busy),
        .rd_data(rd_data));
    laq_check_sva i_laq_check_sva(.clock(clock), .sys_rst(sys_rst),
        .wr_en(bus_if.wr_en), .addr(bus_if.addr), .wdata(bus_if.wdata),
        .rdata(bus_if.rdata), .refresh(bus_if.refresh));
    initial forever #20 clock = ~clock;
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task test_done();
        $display("checks %0d errors %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task check(input logic [27:0] seen, input logic [27:0] want);
        total_checks++;
        if (seen !== want)
        begin
            n_fail++;
            $display("ERROR %0t saw %h want %h", $time, seen, want);
        end
    endtask
    task note(input logic [28:0] x);
        exp_q.push_back(x);
        ->look;
    endtask
    task cfg(input logic en, input logic [23:0] d);
        int i;
        cfg_is_enable = en;
        cfg_data = d;
        cfg_start = 1;
        @(negedge clock);
        cfg_start = 0;
        for (i = 0; cfg_busy !== 1'b0; i++)
        begin
            if (i > 20)
            begin
                n_fail++;
                test_done();
            end
            @(negedge clock);
        end
        repeat (2) @(negedge clock);
    endtask
    task rd(input logic [7:0] a, input logic [23:0] x);
        rd_addr = a;
        repeat (2) @(negedge clock);
        note({5'h10, x});
    endtask
    task stat(input logic [3:0] qq, input logic [22:0] gg);
        note({1'b0, |gg, qq, gg});
    endtask
    initial forever
    begin
        @(look);
        // several notes may land in one time step; take them all
        while (exp_q.size() > 0)
        begin
            e = exp_q.pop_front();
            check(e[28] ? {4'h0, rd_data} : {alert_any, uv_qualified,
                alert_gated}, e[27:0]);
        end
    end
    initial
    begin
        repeat (16) @(negedge clock);
        sys_rst = 0;
        rd(8'h48, 24'h0);
        rd(8'h49, 24'h0);
        rd(8'h50, 24'h0);
        repeat (6)
        begin
            r = xs();
            r2 = xs();
            {oc, uc, ov, op, acc, tally, cyc} = r2[18:0];
            cfg(1'b1, r[23:0]);
            rd(8'h49, r[23:0] & 24'hfffffe);
            g = {oc, uc, ov, 4'h0, op, acc, tally, cyc, 1'b0} & r[23:0];
            stat(4'h0, g[23:1]);
        end
        {oc, uc, ov, op, acc, tally, cyc} = 19'h0;
        for (int t = 0; t < 2; t++)
        begin
            p = t ? 8'he4 : 8'h1b;
            cfg(1'b0, {16'h0, p});
            rd(8'h48, {16'h0, p});
            cfg(1'b1, 24'h000f00);
            for (n = 1; n <= 17; n++)
            begin
                uv_below = (n == 17) ? 4'h0 : 4'hf;
                sample_valid = 1;
                @(negedge clock);
                sample_valid = 0;
                @(negedge clock);
                for (k = 0; k < 4; k++)
                begin
                    c = p >> (2 * k);
                    q[k] = n < 17 && n >= (c[1:0] == 0 ? 1 : 2 << c[1:0]);
                end
                stat(q, {12'h0, q, 7'h0});
            end
        end
        repeat (2) @(negedge clock);
        // a note that was never compared counts as a mismatch
        if (exp_q.size() != 0)
        begin
            n_fail++;
        end
        test_done();
    end
endmodule
